//--- ppp_nvm_core.sv
/*
 * nonvolatile store: flash and eeprom arrays, fuse and lock bytes,
 * and the busy timer that commits a buffered page after the write time.
 * assumes the control port keeps buffers stable while busy is high.
 */
`timescale 1ns/1ps
module ppp_nvm_core
  import ppp_pkg::*;
#(
  parameter int PROG_CYC  = PROG_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        start,       // one-cycle start
  input  wire ppp_pkg::ppp_op_t            op,
  input  wire logic [ppp_pkg::FL_PAGE_W-1:0] fl_page,
  input  wire logic [ppp_pkg::EE_PAGE_W-1:0] ee_page,
  input  wire logic [255:0]                fl_buf,      // 16 words
  input  wire logic [31:0]                 ee_buf,      // 4 bytes
  input  wire logic [3:0]                  ee_mask,     // loaded bytes
  input  wire logic [7:0]                  wr_byte,     // fuse/lock data
  input  wire logic [1:0]                  fuse_sel,    // {second,first}
  input  wire logic [ppp_pkg::FL_ADDR_W-1:0] rd_faddr,
  input  wire logic [ppp_pkg::EE_ADDR_W-1:0] rd_eaddr,
  output logic      [15:0]                 flash_word,
  output logic      [7:0]                  ee_byte,
  output logic      [7:0]                  fuse_lo,
  output logic      [7:0]                  fuse_hi,
  output logic      [7:0]                  fuse_ext,
  output logic      [7:0]                  lock_bits,
  output logic                             busy
);
  import ppp_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [15:0] flash_mem [0:(1<<FL_ADDR_W)-1];  // program words
  logic [7:0]  ee_mem    [0:(1<<EE_ADDR_W)-1];  // data bytes

  ppp_state_t        state, next_state;  // timer state
  logic [BUSY_W-1:0] cnt, next_cnt;      // cycles left
  ppp_op_t           cur_op, next_cur_op;
  logic              next_busy;
  logic [7:0]        next_fuse_lo, next_fuse_hi, next_fuse_ext, next_lock;
  logic              mode3;              // both lock mode bits programmed

  assign mode3      = (lock_bits[1:0] == 2'b00);
  assign flash_word = flash_mem[rd_faddr];
  assign ee_byte    = ee_mem[rd_eaddr];

  // timer and fuse/lock next values
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_cur_op   = cur_op;
    next_fuse_lo  = fuse_lo;
    next_fuse_hi  = fuse_hi;
    next_fuse_ext = fuse_ext;
    next_lock     = lock_bits;
    case (state)
      ST_READY: begin
        if (start && op != OP_NONE) begin
          next_state  = ST_PROG;
          next_cur_op = op;
          next_cnt    = (op == OP_ERASE) ? BUSY_W'(ERASE_CYC - 1) : BUSY_W'(PROG_CYC - 1);
        end
      end
      ST_PROG: begin
        if (cnt == '0) begin
          next_state = ST_COMMIT;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_COMMIT: begin
        next_state = ST_READY;
        // zero bits program a fuse, ones erase it
        if (cur_op == OP_FUSE) begin
          case (fuse_sel)
            2'b00:   next_fuse_lo  = wr_byte;
            2'b01:   next_fuse_hi  = wr_byte;
            2'b10:   next_fuse_ext = wr_byte;
            default: next_fuse_lo  = fuse_lo;
          endcase
        end
        // lock writes only move bits toward programmed; mode 3 freezes the rest
        if (cur_op == OP_LOCK) begin
          next_lock = {lock_bits[7:2] & (mode3 ? 6'h3f : wr_byte[7:2]),
                       lock_bits[1:0] & wr_byte[1:0]};
        end
        if (cur_op == OP_ERASE) begin
          next_lock = BYTE_BLANK;
        end
      end
      default: next_state = ST_READY;
    endcase
    next_busy = (next_state != ST_READY);
  end

  // timer and fuse/lock registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_READY;
      cnt       <= '0;
      cur_op    <= OP_NONE;
      busy      <= 1'b0;
      fuse_lo   <= BYTE_BLANK;
      fuse_hi   <= BYTE_BLANK;
      fuse_ext  <= BYTE_BLANK;
      lock_bits <= BYTE_BLANK;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      cur_op    <= next_cur_op;
      busy      <= next_busy;
      fuse_lo   <= next_fuse_lo;
      fuse_hi   <= next_fuse_hi;
      fuse_ext  <= next_fuse_ext;
      lock_bits <= next_lock;
    end
  end

  // array commit at the end of the write time
  always_ff @(posedge mclk) begin
    if (state == ST_COMMIT) begin
      for (int i = 0; i < (1 << FL_WORD_W); i++) begin
        if (cur_op == OP_FLASH) begin
          flash_mem[{fl_page, FL_WORD_W'(i)}] <= fl_buf[i*16 +: 16];
        end
      end
      for (int i = 0; i < (1 << EE_WORD_W); i++) begin
        if (cur_op == OP_EE && ee_mask[i]) begin
          ee_mem[{ee_page, EE_WORD_W'(i)}] <= ee_buf[i*8 +: 8];
        end
      end
      if (cur_op == OP_ERASE) begin
        for (int i = 0; i < (1 << FL_ADDR_W); i++) begin
          flash_mem[i] <= WORD_BLANK;
        end
        for (int i = 0; i < (1 << EE_ADDR_W); i++) begin
          ee_mem[i] <= BYTE_BLANK;
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_lock_never_erased;
    (state == ST_COMMIT && cur_op == OP_LOCK) |=> ((lock_bits & ~$past(lock_bits)) == 8'h00);
  endproperty
  a_lock_never_erased: assert property (p_lock_never_erased)
    else $error("lock write returned a bit to unprogrammed");
endmodule : ppp_nvm_core

//--- ppp_pkg.sv
/*
 * shared constants and types for the parallel programming port:
 * command codes, load actions, memory geometry, program timing.
 * assumes a 10 MHz mclk; the core, port and bench import this package, the programmer model does not.
 */
package ppp_pkg;
  // ****************************************
  // command bytes
  // ****************************************
  localparam logic [7:0] CMD_NOP      = 8'h00;  // ends page programming
  localparam logic [7:0] CMD_ERASE    = 8'h80;  // chip erase
  localparam logic [7:0] CMD_FUSE_WR  = 8'h40;  // write fuse byte
  localparam logic [7:0] CMD_LOCK_WR  = 8'h20;  // write lock byte
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;  // write flash page
  localparam logic [7:0] CMD_EE_WR    = 8'h11;  // write eeprom page
  localparam logic [7:0] CMD_ID_RD    = 8'h08;  // read id / calibration
  localparam logic [7:0] CMD_FL_RD    = 8'h04;  // read fuse and lock
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;  // read flash word
  localparam logic [7:0] CMD_EE_RD    = 8'h03;  // read eeprom byte

  // ****************************************
  // load actions, operations, core states
  // ****************************************
  typedef enum logic [1:0] {
    ACT_ADDR = 2'b00, ACT_DATA = 2'b01, ACT_CMD = 2'b10, ACT_IDLE = 2'b11
  } ppp_act_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_FLASH = 3'b001, OP_EE = 3'b010,
    OP_FUSE = 3'b011, OP_LOCK = 3'b100, OP_ERASE = 3'b101
  } ppp_op_t;
  typedef enum logic [1:0] {
    ST_READY = 2'b00, ST_PROG = 2'b01, ST_COMMIT = 2'b10
  } ppp_state_t;

  // ****************************************
  // geometry
  // ****************************************
  localparam int FL_ADDR_W = 10;  // flash word address bits
  localparam int FL_WORD_W = 4;   // word within a flash page
  localparam int FL_PAGE_W = FL_ADDR_W - FL_WORD_W;
  localparam int EE_ADDR_W = 7;   // eeprom byte address bits
  localparam int EE_WORD_W = 2;   // byte within an eeprom page
  localparam int EE_PAGE_W = EE_ADDR_W - EE_WORD_W;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  BYTE_BLANK  = 8'hff;  // erased / unprogrammed
  localparam logic [15:0] WORD_BLANK  = 16'hffff;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int T_PROG_MIN_NS   = 3700000;  // page/fuse/lock write
  localparam int T_ERASE_MIN_NS  = 7500000;  // chip erase
  localparam int PROG_CYCLES  = (T_PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = (T_ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 17;  // holds the longest count

  // which operation a write pulse starts under a command
  function automatic ppp_op_t op_of_cmd(input logic [7:0] cmd);
    case (cmd)
      CMD_FLASH_WR: op_of_cmd = OP_FLASH;
      CMD_EE_WR:    op_of_cmd = OP_EE;
      CMD_FUSE_WR:  op_of_cmd = OP_FUSE;
      CMD_LOCK_WR:  op_of_cmd = OP_LOCK;
      CMD_ERASE:    op_of_cmd = OP_ERASE;
      default:      op_of_cmd = OP_NONE;
    endcase
  endfunction : op_of_cmd
endpackage : ppp_pkg

//--- ppp_prog_model.sv
/* programmer model: drives load and write strobes, selects and the bus.
   assumes the bench clock; pins change on the falling edge of mclk. */
`timescale 1ns/1ps
module ppp_prog_model (
  input  wire logic       mclk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       done_flag,
  output logic      [1:0] act,
  output logic            sel_first,
  output logic            sel_second,
  output logic            strobe,
  output logic            write_n,
  output logic            out_en_n,
  output logic      [7:0] data_in
);
  logic [7:0] drv  = 8'h00;  // byte offered
  logic       own  = 1'b0;   // programmer drives the bus
  logic [7:0] last = 8'h00;  // last bus level
  // ****************************************
  // bus wire; a released bus toggles
  // ****************************************
  assign data_in = data_oe ? data_out : (own ? drv : ~last);
  always @(posedge mclk) last <= data_in;
  initial begin
    act = 2'b11;
    {sel_first, sel_second, strobe} = 3'b000;
    {write_n, out_en_n} = 2'b11;
  end
  // one load: pins set with strobe high, then strobe low, then release
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
    @(negedge mclk);
    {act, sel_first, drv, own, strobe} = {a, b, d, 2'b11};
    @(negedge mclk);
    strobe = 1'b0;
    @(negedge mclk);
    {act, own} = 3'b110;
  endtask : load
  // write pulse, then wait for ready; lowc is -1 on timeout
  task automatic pulse(input logic b1, input logic b2, output int lowc);
    lowc = 0;
    @(negedge mclk);
    {sel_first, sel_second, write_n} = {b1, b2, 1'b0};
    @(negedge mclk);
    write_n = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk);
      if (done_flag === 1'b0) lowc++;
      else if (lowc > 0) break;
    end
    if (done_flag !== 1'b1) lowc = -1;
    {sel_first, sel_second} = 2'b00;
  endtask : pulse
  // read: enable output, let it settle, sample the bus
  task automatic read(input logic b1, input logic b2, output logic [7:0] q, output logic oe);
    @(negedge mclk);
    {sel_first, sel_second, out_en_n} = {b1, b2, 1'b0};
    @(negedge mclk);
    @(negedge mclk);
    {q, oe} = {data_in, data_oe};
    out_en_n = 1'b1;
  endtask : read
endmodule : ppp_prog_model

//--- ppp_prog_port.sv
/*
 * parallel programming port: decodes load and write strobes, holds
 * command, address, data and page buffers, drives the data bus on reads.
 * assumes all pins synchronous to mclk and strobes at least one cycle wide.
 */
`timescale 1ns/1ps
module ppp_prog_port
  import ppp_pkg::*;
#(
  parameter int          PROG_CYC  = PROG_CYCLES,   // page write time
  parameter int          ERASE_CYC = ERASE_CYCLES,  // chip erase time
  parameter logic [7:0]  ID_BYTE0  = 8'h5a,  // arbitrary value
  parameter logic [7:0]  ID_BYTE1  = 8'h3c,  // arbitrary value
  parameter logic [7:0]  ID_BYTE2  = 8'h01,  // arbitrary value
  parameter logic [7:0]  CAL_BYTE  = 8'h80   // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       action_select_hi,
  input  wire logic       action_select_lo,
  input  wire logic       byte_select_first,
  input  wire logic       byte_select_second,
  input  wire logic       load_strobe,
  input  wire logic       write_n,
  input  wire logic       out_en_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            done_flag
);
  import ppp_pkg::*;

  // ****************************************
  // strobe edges
  // ****************************************
  logic     load_prev, write_prev;  // last sampled strobe levels
  logic     load_rise, write_fall;  // one-cycle events
  ppp_act_t act;                    // current load action

  assign act        = ppp_act_t'({action_select_hi, action_select_lo});
  assign load_rise  = load_strobe && !load_prev;
  assign write_fall = !write_n && write_prev;

  // edge history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_prev  <= 1'b0;
      write_prev <= 1'b1;
    end else begin
      load_prev  <= load_strobe;
      write_prev <= write_n;
    end
  end

  // ****************************************
  // command, address, data and page buffers
  // ****************************************
  logic [7:0]   cmd, next_cmd;          // last loaded command
  logic [15:0]  addr, next_addr;        // {high,low} address
  logic [7:0]   dlo, next_dlo;          // data low byte
  logic [7:0]   dhi, next_dhi;          // data high byte
  logic [255:0] fl_buf, next_fl_buf;    // flash page buffer
  logic [31:0]  ee_buf, next_ee_buf;    // eeprom page buffer
  logic [3:0]   ee_mask, next_ee_mask;  // eeprom bytes loaded
  logic         core_busy;              // write in progress
  logic [FL_WORD_W-1:0] fword;          // word within flash page
  logic [EE_WORD_W-1:0] eword;          // byte within eeprom page

  assign fword = addr[FL_WORD_W-1:0];
  assign eword = addr[EE_WORD_W-1:0];

  // load decode
  always_comb begin
    next_cmd     = cmd;
    next_addr    = addr;
    next_dlo     = dlo;
    next_dhi     = dhi;
    next_fl_buf  = fl_buf;
    next_ee_buf  = ee_buf;
    next_ee_mask = ee_mask;
    if (load_rise) begin
      case (act)
        ACT_CMD: begin
          next_cmd = data_in;
          if (data_in == CMD_NOP) begin
            next_fl_buf  = {16{WORD_BLANK}};
            next_ee_buf  = {4{BYTE_BLANK}};
            next_ee_mask = 4'h0;
          end
        end
        ACT_ADDR: begin
          if (byte_select_first) begin
            next_addr[15:8] = data_in;
          end else begin
            next_addr[7:0] = data_in;
          end
        end
        ACT_DATA: begin
          if (byte_select_first) begin
            next_dhi = data_in;
            if (cmd == CMD_FLASH_WR) begin
              next_fl_buf[fword*16 +: 16] = {data_in, dlo};
            end
          end else begin
            next_dlo = data_in;
            if (cmd == CMD_EE_WR) begin
              next_ee_buf[eword*8 +: 8] = data_in;
              next_ee_mask[eword]       = 1'b1;
            end
          end
        end
        ACT_IDLE: next_cmd = cmd;
        default:  next_cmd = cmd;
      endcase
    end
  end

  // load registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd     <= CMD_NOP;
      addr    <= 16'h0000;
      dlo     <= BYTE_BLANK;
      dhi     <= BYTE_BLANK;
      fl_buf  <= {16{WORD_BLANK}};
      ee_buf  <= {4{BYTE_BLANK}};
      ee_mask <= 4'h0;
    end else begin
      cmd     <= next_cmd;
      addr    <= next_addr;
      dlo     <= next_dlo;
      dhi     <= next_dhi;
      fl_buf  <= next_fl_buf;
      ee_buf  <= next_ee_buf;
      ee_mask <= next_ee_mask;
    end
  end

  // ****************************************
  // write start and store
  // ****************************************
  ppp_op_t    wr_op;     // operation for the loaded command
  logic       start;     // accepted write pulse
  logic [15:0] rd_word;  // addressed flash word
  logic [7:0] rd_ee, fz_lo, fz_hi, fz_ext, lk;

  assign wr_op = op_of_cmd(cmd);
  // eeprom page write wants the first select low; busy ignores pulses
  assign start = write_fall && !core_busy && wr_op != OP_NONE &&
                 !(wr_op == OP_EE && byte_select_first);

  ppp_nvm_core #(
    .PROG_CYC  (PROG_CYC),
    .ERASE_CYC (ERASE_CYC)
  ) u_core (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .start      (start),
    .op         (wr_op),
    .fl_page    (addr[FL_ADDR_W-1:FL_WORD_W]),
    .ee_page    (addr[EE_ADDR_W-1:EE_WORD_W]),
    .fl_buf     (fl_buf),
    .ee_buf     (ee_buf),
    .ee_mask    (ee_mask),
    .wr_byte    (dlo),
    .fuse_sel   ({byte_select_second, byte_select_first}),
    .rd_faddr   (addr[FL_ADDR_W-1:0]),
    .rd_eaddr   (addr[EE_ADDR_W-1:0]),
    .flash_word (rd_word),
    .ee_byte    (rd_ee),
    .fuse_lo    (fz_lo),
    .fuse_hi    (fz_hi),
    .fuse_ext   (fz_ext),
    .lock_bits  (lk),
    .busy       (core_busy)
  );

  // ****************************************
  // read mux and bus drive
  // ****************************************
  logic [7:0] next_data_out;
  logic       next_data_oe, next_done;

  // byte presented for the loaded command and selects
  always_comb begin
    next_data_out = BYTE_BLANK;
    case (cmd)
      CMD_FLASH_RD: next_data_out = byte_select_first ? rd_word[15:8] : rd_word[7:0];
      CMD_EE_RD:    next_data_out = rd_ee;
      CMD_FL_RD: begin
        case ({byte_select_second, byte_select_first})
          2'b00:   next_data_out = fz_lo;
          2'b11:   next_data_out = fz_hi;
          2'b10:   next_data_out = fz_ext;
          default: next_data_out = lk;
        endcase
      end
      CMD_ID_RD: begin
        if (byte_select_first) begin
          next_data_out = (addr[7:0] == 8'h00) ? CAL_BYTE : BYTE_BLANK;
        end else begin
          case (addr[7:0])
            8'h00:   next_data_out = ID_BYTE0;
            8'h01:   next_data_out = ID_BYTE1;
            8'h02:   next_data_out = ID_BYTE2;
            default: next_data_out = BYTE_BLANK;
          endcase
        end
      end
      default: next_data_out = BYTE_BLANK;
    endcase
    next_data_oe = !out_en_n;
    next_done    = !core_busy && !start;
  end

  // output registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out  <= 8'h00;
      data_oe   <= 1'b0;
      done_flag <= 1'b1;
    end else begin
      data_out  <= next_data_out;
      data_oe   <= next_data_oe;
      done_flag <= next_done;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_load(ppp_act_t a);
    load_rise && act == a;
  endsequence
  sequence s_busy_run;
    !done_flag [*4];
  endsequence

  property p_cmd_load;
    s_load(ACT_CMD) |=> cmd == $past(data_in);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("command not captured");

  property p_addr_lo;
    s_load(ACT_ADDR) ##0 !byte_select_first |=> addr[7:0] == $past(data_in) && $stable(addr[15:8]);
  endproperty
  a_addr_lo: assert property (p_addr_lo)
    else $error("address low not captured");

  property p_addr_hi;
    s_load(ACT_ADDR) ##0 byte_select_first |=> addr[15:8] == $past(data_in) && $stable(addr[7:0]);
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("address high not captured");

  property p_data_load;
    s_load(ACT_DATA) |=> (byte_select_first ? dhi : dlo) == $past(data_in);
  endproperty
  a_data_load: assert property (p_data_load)
    else $error("data byte not captured");

  property p_idle_load;
    s_load(ACT_IDLE) |=> $stable(cmd) && $stable(addr) && $stable(dlo) && $stable(dhi);
  endproperty
  a_idle_load: assert property (p_idle_load)
    else $error("idle load changed state");

  property p_nop_clears;
    s_load(ACT_CMD) ##0 data_in == CMD_NOP |=> ee_mask == 4'h0 && fl_buf == {16{WORD_BLANK}};
  endproperty
  a_nop_clears: assert property (p_nop_clears)
    else $error("no-op left buffers loaded");

  property p_prog_busy;
    start |=> s_busy_run;
  endproperty
  a_prog_busy: assert property (p_prog_busy)
    else $error("done flag not low after write pulse");

  property p_bus_release;
    out_en_n |=> !data_oe;
  endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("bus driven with output enable high");

  property p_flash_read;
    cmd == CMD_FLASH_RD && !byte_select_first && !out_en_n |=> data_out == $past(rd_word[7:0]);
  endproperty
  a_flash_read: assert property (p_flash_read)
    else $error("flash low byte not presented");

  property p_cmd_kept;
    !load_rise |=> $stable(cmd) && $stable(addr);
  endproperty
  a_cmd_kept: assert property (p_cmd_kept)
    else $error("command or address lost");
endmodule : ppp_prog_port

//--- tb_top.sv
/* self-checking bench for the parallel programming port.
   assumes ppp_pkg and the programmer model; short write times. */
`timescale 1ns/1ps
module tb_top;
  import ppp_pkg::*;
  localparam int PC = 8;   // shortened page write time
  localparam int EC = 12;  // shortened erase time
  localparam logic [7:0] ID0 = 8'h5a, ID1 = 8'h3c, ID2 = 8'h01, CAL = 8'h80;  // arbitrary
  typedef struct packed {logic [7:0] cmd; logic [7:0] adr; logic b1; logic b2; logic [7:0] exp;} ppp_row_t;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] act;
  logic       sel_first, sel_second, strobe, write_n, out_en_n, oe, data_oe, done_flag;
  logic [7:0] data_in, data_out, q;
  logic [7:0] fv [3] = '{8'he1, 8'hd2, 8'hfe};  // fuse bytes written
  logic [7:0] lv [3] = '{8'hfc, 8'hff, 8'h00};  // lock bytes written
  int         n_errors = 0, tests_run = 0, c;
  // ****************************************
  // read table: command, address, selects, expected byte
  // ****************************************
  ppp_row_t rows [11] = '{{CMD_FLASH_RD, 8'h12, 2'b00, 8'ha5}, {CMD_FLASH_RD, 8'h12, 2'b10, 8'h3c},
    {CMD_EE_RD, 8'h05, 2'b00, 8'h77}, {CMD_FL_RD, 8'h00, 2'b00, 8'he1}, {CMD_FL_RD, 8'h00, 2'b11, 8'hd2},
    {CMD_FL_RD, 8'h00, 2'b01, 8'hfe}, {CMD_FL_RD, 8'h00, 2'b10, 8'hfc}, {CMD_ID_RD, 8'h00, 2'b00, ID0},
    {CMD_ID_RD, 8'h01, 2'b00, ID1}, {CMD_ID_RD, 8'h02, 2'b00, ID2}, {CMD_ID_RD, 8'h00, 2'b10, CAL}};
  initial forever #50 mclk = ~mclk;
  ppp_prog_port #(.PROG_CYC(PC), .ERASE_CYC(EC), .ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2),
    .CAL_BYTE(CAL)) dut (.mclk(mclk), .rst_n(rst_n), .action_select_hi(act[1]), .action_select_lo(act[0]),
    .byte_select_first(sel_first), .byte_select_second(sel_second), .load_strobe(strobe), .write_n(write_n),
    .out_en_n(out_en_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .done_flag(done_flag));
  ppp_prog_model pm (.mclk(mclk), .data_out(data_out), .data_oe(data_oe), .done_flag(done_flag), .act(act),
    .sel_first(sel_first), .sel_second(sel_second), .strobe(strobe), .write_n(write_n),
    .out_en_n(out_en_n), .data_in(data_in));
  // ****************************************
  // compare tasks and closing report
  // ****************************************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chkn(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chkn
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // load command and address, idle load, then read one byte
  task automatic rd(input ppp_row_t r);
    pm.load(2'b10, 1'b0, r.cmd);
    pm.load(2'b00, 1'b0, r.adr);
    pm.load(2'b11, 1'b0, 8'h00);
    pm.read(r.b1, r.b2, q, oe);
    chk8("bus drive", 8'h01, {7'h00, oe});
    chk8("read byte", r.exp, q);
  endtask : rd
  // write pulse and busy length; a hang ends the run
  task automatic prog(input logic b1, input logic b2, input int exp);
    pm.pulse(b1, b2, c);
    chkn("busy cycles", exp, c);
    if (c < 0) report_and_stop();
  endtask : prog
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    chk8("ready after reset", 8'h01, {7'h00, done_flag});
    chk8("drive after reset", 8'h00, {7'h00, data_oe});
    pm.load(2'b10, 1'b0, CMD_FLASH_WR);
    pm.load(2'b00, 1'b0, 8'h12);
    pm.load(2'b01, 1'b0, 8'ha5);
    pm.load(2'b01, 1'b1, 8'h3c);
    pm.load(2'b00, 1'b1, 8'h00);
    prog(1'b0, 1'b0, PC + 1);
    pm.load(2'b10, 1'b0, CMD_EE_WR);
    pm.load(2'b00, 1'b1, 8'h00);
    pm.load(2'b00, 1'b0, 8'h05);
    pm.load(2'b01, 1'b0, 8'h77);
    prog(1'b0, 1'b0, PC + 1);
    prog(1'b1, 1'b0, 0);
    $display("test page writes done");
    pm.load(2'b10, 1'b0, CMD_FUSE_WR);
    for (int t = 0; t < 3; t++) begin
      pm.load(2'b01, 1'b0, fv[t]);
      prog(t == 1, t == 2, PC + 1);
    end
    pm.load(2'b10, 1'b0, CMD_LOCK_WR);
    for (int t = 0; t < 3; t++) begin
      pm.load(2'b01, 1'b0, lv[t]);
      prog(1'b0, 1'b0, PC + 1);
    end
    $display("test fuse and lock writes done");
    foreach (rows[i]) rd(rows[i]);
    @(negedge mclk);
    chk8("bus released", 8'h00, {7'h00, data_oe});
    $display("test read table done");
    pm.load(2'b10, 1'b0, CMD_NOP);
    pm.load(2'b10, 1'b0, CMD_FLASH_WR);
    pm.load(2'b00, 1'b0, 8'h12);
    prog(1'b0, 1'b0, PC + 1);
    rd({CMD_FLASH_RD, 8'h12, 2'b00, 8'hff});
    $display("test no-op buffer clear done");
    pm.load(2'b10, 1'b0, CMD_ERASE);
    prog(1'b0, 1'b0, EC + 1);
    rd({CMD_FL_RD, 8'h00, 2'b10, 8'hff});
    rd({CMD_EE_RD, 8'h05, 2'b00, 8'hff});
    rd({CMD_FL_RD, 8'h00, 2'b00, 8'he1});
    $display("test chip erase done");
    // mid-run reset: ready and bus released at once, port usable again
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk8("ready after second reset", 8'h01, {7'h00, done_flag});
    chk8("drive after second reset", 8'h00, {7'h00, data_oe});
    rd({CMD_FL_RD, 8'h00, 2'b10, 8'hff});
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : tb_top
